//--- design/swi_detect.sv
// level or edge detector with pending latch for one wake source
`timescale 1ns/1ps
module swi_detect
  import swi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       src,          // source level, already in clk domain
  input  wire logic       enable,       // release enable
  input  wire logic [1:0] mode,         // active state selection
  input  wire logic       clear,        // one-cycle clear pulse
  output logic            pending       // latched request, level
);
  logic prev_reg;                       // source one cycle ago
  logic pend_reg;                       // pending latch
  logic hit;                            // active state seen this cycle

  // previous sample for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= src;
    end
  end

  // active state decode, gated by the enable
  always_comb begin
    hit = 1'b0;
    unique case (mode)
      SWI_MODE_LOW:  hit = !src;
      SWI_MODE_HIGH: hit = src;
      SWI_MODE_FALL: hit = prev_reg && !src;
      SWI_MODE_RISE: hit = !prev_reg && src;
    endcase
    hit = hit && enable;
  end

  // set wins over clear so an event in the clear cycle is kept
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_reg <= 1'b0;
    end else if (hit) begin
      pend_reg <= 1'b1;
    end else if (clear) begin
      pend_reg <= 1'b0;
    end
  end

  assign pending = pend_reg;
endmodule

//--- design/swi_pkg.sv
// constants for the standby wake interrupt clear block
package swi_pkg;
  // source count and source index layout
  localparam int          SWI_SRC_N       = 15;   // fifteen standby-release sources
  localparam int          SWI_EXT_N       = 12;   // external interrupt inputs
  localparam int          SWI_SRC_KEY     = 12;   // combined key wake-up source
  localparam int          SWI_SRC_TICK    = 13;   // clock-tick source
  localparam int          SWI_SRC_TBASE   = 14;   // time-base source

  // register byte addresses
  localparam logic [31:0] SWI_CFG_A_ADDR  = 32'hFFFF_EE10; // sources 0..3
  localparam logic [31:0] SWI_CFG_B_ADDR  = 32'hFFFF_EE14; // sources 4..7
  localparam logic [31:0] SWI_CFG_C_ADDR  = 32'hFFFF_EE18; // sources 8..11
  localparam logic [31:0] SWI_CFG_D_ADDR  = 32'hFFFF_EE1C; // key, tick, time base
  localparam logic [31:0] SWI_CLEAR_ADDR  = 32'hFFFF_EE20; // standby_request_clear
  localparam logic [31:0] SWI_STATUS_ADDR = 32'hFFFF_EE28; // pending status, read only

  // register selector codes from the address decoder
  localparam logic [2:0]  SWI_SEL_CLEAR   = 3'h4;
  localparam logic [2:0]  SWI_SEL_STATUS  = 3'h5;
  localparam logic [2:0]  SWI_SEL_NONE    = 3'h7;

  // field layout inside each configuration byte lane
  localparam int          SWI_EN_BIT      = 0;    // release enable
  localparam int          SWI_MODE_LSB    = 4;    // two-bit active state field
  localparam int          SWI_LANE_W      = 8;    // one source per byte lane
  localparam int          SWI_CODE_W      = 4;    // clear code width

  // reset values
  localparam logic        SWI_EN_RST      = 1'b0;
  localparam logic [1:0]  SWI_MODE_RST    = 2'h2; // same code as SWI_MODE_FALL, the falling-edge state
  localparam logic [31:0] SWI_WORD_ZERO   = 32'h0000_0000;

  // active state encodings
  localparam logic [1:0]  SWI_MODE_LOW    = 2'h0;
  localparam logic [1:0]  SWI_MODE_HIGH   = 2'h1;
  localparam logic [1:0]  SWI_MODE_FALL   = 2'h2;
  localparam logic [1:0]  SWI_MODE_RISE   = 2'h3;

  // reserved clear code, ignored on write
  localparam logic [3:0]  SWI_CODE_RSVD   = 4'hF;
endpackage

//--- design/swi_top.sv
// standby wake source configuration, detection and request clear over apb
//
// Functional notes
// - two-bit active state: low, high, fall, rise
// - fifteen sources: twelve external, tick, timebase, key
// - external enable and state held here
// - key enable here, key levels outside
// - tick and time-base enable and state held here too
// - four-bit code clears selected source request
`timescale 1ns/1ps
module swi_top
  import swi_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [SWI_EXT_N-1:0] external_irq,
  input  wire logic                 key_wakeup,
  input  wire logic                 clock_tick_interrupt,
  input  wire logic                 timebase_interrupt,
  output logic      [SWI_SRC_N-1:0] wake_request,
  output logic                      standby_release
);

  // register map: three words of external source lanes, one word for
  // key, tick and time base, the clear code word and a read-only status
  // word; any other address answers with pslverr and changes nothing
  // address decoder, used for both setup-phase read and access-phase write
  function automatic logic [2:0] reg_sel(input logic [31:0] addr);
    logic [2:0] sel;
    sel = SWI_SEL_NONE;
    unique case (addr)
      SWI_CFG_A_ADDR:  sel = 3'h0;
      SWI_CFG_B_ADDR:  sel = 3'h1;
      SWI_CFG_C_ADDR:  sel = 3'h2;
      SWI_CFG_D_ADDR:  sel = 3'h3;
      SWI_CLEAR_ADDR:  sel = SWI_SEL_CLEAR;
      SWI_STATUS_ADDR: sel = SWI_SEL_STATUS;
      default:         sel = SWI_SEL_NONE;
    endcase
    return sel;
  endfunction

  // per-source configuration and state
  logic [SWI_SRC_N-1:0] en_reg;               // release enables
  logic [1:0]           mode_reg [SWI_SRC_N]; // active state per source
  logic [SWI_SRC_N-1:0] clr_reg;              // one-cycle clear pulses
  logic [SWI_SRC_N-1:0] pending;              // latched requests
  logic [SWI_SRC_N-1:0] g_det_pending;        // detector latch outputs
  logic [SWI_SRC_N-1:0] src_level;            // source levels in clk domain
  // only the second stage reads the first, so no logic sees a metastable bit
  logic [SWI_EXT_N-1:0] ext_meta_reg;         // first synchroniser stage
  logic [SWI_EXT_N-1:0] ext_sync_reg;         // second synchroniser stage

  // bus state
  logic [31:0]          prdata_reg;           // read data, loaded in setup
  logic                 pready_reg;           // high during the access phase
  logic                 pslverr_reg;          // unmapped address flag
  logic                 standby_release_reg;  // any pending request
  logic [2:0]           setup_sel;            // decode in setup
  logic [2:0]           acc_sel;              // decode in access
  logic                 wr_fire;              // write completes this edge
  logic [31:0]          rd_word;              // assembled read value

  // the address stands unchanged from setup through access, so the same
  // decode serves both phases
  assign setup_sel = reg_sel(paddr);
  assign acc_sel   = reg_sel(paddr);
  assign wr_fire   = psel && penable && pready_reg && pwrite;

  // external pins cross into clk through two flops each
  // a detector sees a pin change two edges late; a pin pulse must last
  // at least one full clock or it may be missed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_meta_reg <= '0;
      ext_sync_reg <= '0;
    end else begin
      ext_meta_reg <= external_irq;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  // source order matches the clear codes; tick, time base and key
  // come from on-chip logic on this clock, so no synchroniser
  assign src_level = {timebase_interrupt, clock_tick_interrupt,
                      key_wakeup, ext_sync_reg};

  // configuration writes: one byte lane per source, four per word
  // the upper byte of the key word has no flops behind it, so writes
  // there are lost and it reads zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_reg <= '0;
      for (int s = 0; s < SWI_SRC_N; s++) begin
        mode_reg[s] <= SWI_MODE_RST;
      end
    end else if (wr_fire) begin
      for (int s = 0; s < SWI_SRC_N; s++) begin
        // external, key, tick and time-base enables with their states live here
        if (acc_sel == 3'(s / 4)) begin
          en_reg[s]   <= pwdata[SWI_LANE_W*(s%4) + SWI_EN_BIT];
          mode_reg[s] <= pwdata[SWI_LANE_W*(s%4) + SWI_MODE_LSB +: 2];
        end
      end
    end
  end

  // clear code register: decode to a pulse, reserved code is dropped
  // the pulse lasts one cycle, so the latch clears one edge after the
  // write; an event in that same cycle still sets it again
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clr_reg <= '0;
    end else begin
      clr_reg <= '0;
      if (wr_fire && acc_sel == SWI_SEL_CLEAR &&
          pwdata[SWI_CODE_W-1:0] != SWI_CODE_RSVD) begin
        clr_reg[pwdata[SWI_CODE_W-1:0]] <= 1'b1;
      end
    end
  end

  // one detector per source
  // every lane is the same edge and latch logic, so one generate loop
  // keeps the fifteen copies identical
  genvar g;
  generate
    for (g = 0; g < SWI_SRC_N; g++) begin : g_det
      swi_detect u_det (
        .clk     (clk),
        .arst_n  (arst_n),
        .src     (src_level[g]),
        .enable  (en_reg[g]),
        .mode    (mode_reg[g]),
        .clear   (clr_reg[g]),
        .pending (g_det_pending[g])
      );
    end
  endgenerate

  // collect detector outputs
  assign pending = g_det_pending;

  // read value assembly; the clear register always reads zero
  // built from the setup address, so status shows the latches as they
  // stood at the setup edge
  always_comb begin
    rd_word = SWI_WORD_ZERO;
    if (setup_sel == SWI_SEL_STATUS) begin
      rd_word[SWI_SRC_N-1:0] = pending;
    end else if (setup_sel < SWI_SEL_CLEAR) begin
      for (int s = 0; s < SWI_SRC_N; s++) begin
        if (setup_sel == 3'(s / 4)) begin
          rd_word[SWI_LANE_W*(s%4) + SWI_EN_BIT]        = en_reg[s];
          rd_word[SWI_LANE_W*(s%4) + SWI_MODE_LSB +: 2] = mode_reg[s];
        end
      end
    end
  end

  // apb slave: one wait-free access phase after every setup
  // pready rises for the access phase and falls at the next edge, so
  // back-to-back transfers need no idle cycle between them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= SWI_WORD_ZERO;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      // setup: answer is ready at the next edge
      pready_reg  <= 1'b1;
      prdata_reg  <= pwrite ? SWI_WORD_ZERO : rd_word;
      pslverr_reg <= (setup_sel == SWI_SEL_NONE);
    end else begin
      // access done or idle: drop the answer
      pready_reg  <= 1'b0;
      prdata_reg  <= SWI_WORD_ZERO;
      pslverr_reg <= 1'b0;
    end
  end

  // combined release request toward the standby control
  // one cycle behind wake_request; standby control only needs a level,
  // so the extra flop costs nothing and keeps the output registered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      standby_release_reg <= 1'b0;
    end else begin
      standby_release_reg <= |pending;
    end
  end

  // every output below is a plain flop output
  // only the fifteen release sources leave here; others go straight
  // to the cpu_interrupt_controller and never enter this block
  assign wake_request    = pending;
  assign standby_release = standby_release_reg;
  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
endmodule

//--- design/swi_top_fix.sv
// holds no logic: the block is swi_top with one swi_detect per source

//--- testbench/swi_src_model.sv
// source side model: one stretched pulse line per source, for pins, key wake, tick and time base
`timescale 1ns/1ps
module swi_src_model
  import swi_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic [SWI_SRC_N-1:0] fire,
  output logic      [SWI_SRC_N-1:0] line
);
  logic [SWI_SRC_N-1:0] held_reg; // stretches each command by one cycle
  // a command gives a two-cycle high pulse, then the line idles low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held_reg <= '0;
    end else begin
      held_reg <= fire;
    end
  end
  // key group arrives as one combined request, active high
  // the key line drops by itself two cycles after its command, whether or not its status is cleared
  assign line = fire | held_reg;
endmodule

//--- testbench/swi_top_asserts.sv
// port checker for the standby wake clear block
`timescale 1ns/1ps
module swi_top_asserts
  import swi_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 arst_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [SWI_SRC_N-1:0] wake_request,
  input wire logic                 standby_release
);
  logic                 mapped;  // address hits a register
  logic [SWI_SRC_N-1:0] clr_vec; // one-hot clear taken this cycle
  assign mapped = paddr inside {SWI_CFG_A_ADDR, SWI_CFG_B_ADDR, SWI_CFG_C_ADDR,
                                SWI_CFG_D_ADDR, SWI_CLEAR_ADDR, SWI_STATUS_ADDR};
  // reserved code shifts out of range, so it clears nothing
  assign clr_vec = (psel && penable && pready && pwrite && paddr == SWI_CLEAR_ADDR) ?
                   15'h1 << pwdata[3:0] : '0;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_idle_quiet: assert property (!pready |-> prdata == SWI_WORD_ZERO && !pslverr)
    else $error("read bus busy while idle");
  chk_clear_reads: assert property (pready && !pwrite && paddr == SWI_CLEAR_ADDR
    |-> prdata == SWI_WORD_ZERO)
    else $error("clear register read nonzero");
  chk_err_decode: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  chk_release_lag: assert property (1'b1 |=> standby_release == |$past(wake_request))
    else $error("release not one cycle behind requests");
  chk_fall_cause: assert property (($past(wake_request) & ~wake_request
    & ~$past(clr_vec, 2)) == '0)
    else $error("request dropped without its clear code");
  chk_status_mirror: assert property (pready && !pwrite && paddr == SWI_STATUS_ADDR
    |-> prdata == {17'h0, $past(wake_request)})
    else $error("status differs from requests");
  cover property (pslverr);
  cover property (|clr_vec);
  cover property ($rose(standby_release));
endmodule
bind swi_top swi_top_asserts u_chk (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .wake_request(wake_request), .standby_release(standby_release));

//--- testbench/tb_top.sv
// self-checking bench for the standby wake clear block
`timescale 1ns/1ps
module tb_top
  import swi_pkg::*;
;
  logic                 clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0]          paddr = '0, pwdata = '0, prdata, cfg_a;
  logic                 pready, pslverr, standby_release;
  logic [SWI_SRC_N-1:0] fire = '0, line, wake_request;
  logic [33:0]          exp_q[$];  // write flag, error, data per transfer
  logic [SWI_SRC_N-1:0] rel_q[$];  // requests expected at each release rise
  logic                 rel_prev = 1'b0; // release as seen one edge ago
  logic [31:0]          codes[4] = '{32'hD, 32'hF, 32'hC, 32'hE};
  logic [31:0]          left[4] = '{32'h5000, 32'h5000, 32'h4000, 32'h0};
  int                   fails = 0, check_count = 0, seed = 32'ha5fd, idx;
  always #20 clk = ~clk;
  swi_top u_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_irq(line[11:0]), .key_wakeup(line[12]), .clock_tick_interrupt(line[13]),
    .timebase_interrupt(line[14]), .wake_request(wake_request),
    .standby_release(standby_release));
  swi_src_model u_src (.clk(clk), .arst_n(arst_n), .fire(fire), .line(line));
  task automatic conclude();
    fails += exp_q.size() + rel_q.size(); // notes with no result are misses
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t read data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cmp_req(input logic [SWI_SRC_N-1:0] got, input logic [SWI_SRC_N-1:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t requests %h expected %h", $time, got, exp);
    end
  endtask
  // one bus transfer; note the expectation, hold until ready
  task automatic apb(input logic w, input logic [31:0] a, d, input logic er, input logic [31:0] e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back({w, er, e});
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d, 1'b0, '0);
  endtask
  task automatic rd(input logic [31:0] a, e);
    apb(1'b0, a, '0, 1'b0, e);
  endtask
  // one source command, then settle past the sync and latch stages
  task automatic pulse(input int s);
    @(posedge clk);
    fire[s] <= 1'b1;
    @(posedge clk);
    fire <= '0;
    repeat (8) @(posedge clk);
  endtask
  // scoreboard: oldest note against each completed transfer
  always @(posedge clk) begin
    logic [33:0] e;
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      cmp_flag(pslverr, e[32]);
      if (!e[33]) cmp_word(prdata, e[31:0]);
    end
  end
  // release watcher: every rise of standby_release must have been noted
  always @(posedge clk) begin
    if (arst_n && standby_release === 1'b1 && rel_prev === 1'b0) begin
      if (rel_q.size() == 0) begin
        cmp_flag(standby_release, 1'b0);
      end else begin
        cmp_req(wake_request, rel_q.pop_front());
      end
    end
    rel_prev <= standby_release;
  end
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 3; i++) rd(SWI_CFG_A_ADDR + 32'(4 * i), 32'h2020_2020);
    rd(SWI_CFG_D_ADDR, 32'h0020_2020);
    rd(SWI_CLEAR_ADDR, SWI_WORD_ZERO);
    apb(1'b0, 32'hFFFF_EE2C, '0, 1'b1, SWI_WORD_ZERO);
    apb(1'b1, 32'hFFFF_EE00, '1, 1'b1, '0);
    wr(SWI_STATUS_ADDR, '1);
    rd(SWI_STATUS_ADDR, SWI_WORD_ZERO);
    $display("test reset_map done");
    // every active state on a random external source
    for (int m = 0; m < 4; m++) begin
      idx = $unsigned($random(seed)) % SWI_EXT_N;
      cfg_a = SWI_CFG_A_ADDR + 32'(4 * (idx / 4));
      wr(cfg_a, 32'(m) << (8 * (idx % 4) + 4));
      rel_q.push_back(15'(32'h1 << idx));
      wr(cfg_a, ((32'(m) << 4) | 32'h1) << (8 * (idx % 4)));
      pulse(idx);
      rd(SWI_STATUS_ADDR, 32'h1 << idx);
      wr(cfg_a, SWI_WORD_ZERO);
      rd(SWI_STATUS_ADDR, 32'h1 << idx);
      wr(SWI_CLEAR_ADDR, 32'(idx));
      rd(SWI_STATUS_ADDR, SWI_WORD_ZERO);
    end
    // a disabled source is a plain interrupt and must not latch here
    pulse(idx);
    rd(SWI_STATUS_ADDR, SWI_WORD_ZERO);
    $display("test ext_modes done");
    wr(SWI_CFG_D_ADDR, '1);
    rd(SWI_CFG_D_ADDR, 32'h0031_3131);
    wr(SWI_CFG_D_ADDR, 32'h0031_3111);
    rel_q.push_back(15'(32'h1 << SWI_SRC_KEY));
    for (int s = SWI_SRC_KEY; s < SWI_SRC_N; s++) pulse(s);
    rd(SWI_STATUS_ADDR, 32'h7000);
    for (int k = 0; k < 4; k++) begin
      wr(SWI_CLEAR_ADDR, codes[k]);
      rd(SWI_STATUS_ADDR, left[k]);
    end
    $display("test group_codes done");
    repeat (2) @(posedge clk);
    conclude();
  end
  initial begin
    #2000000;
    fails++;
    conclude();
  end
endmodule
